// ==== rtl/bdl_pkg.sv ====
// Package: constants, types and register map of the diagnostic LED controller
// Functional notes
// - Fan fault lamp lit while fan faults
// - Memory lamp needs populated socket and error
// - Identify button press toggles solid lamp
// - Remote identify blinks 15 s or forever
// - Steady green only when healthy and ready
// - Degraded conditions blink green at 1 Hz
// - Spare migration degrades and lights memory lamp
// - Non-fatal alarms blink amber at 1 Hz
// - Fatal conditions give steady amber
// - Boot loader: degraded, identify blinks 3 Hz
// - Main image boot: degraded, identify solid
// - Controller self-test failure: amber, identify solid
// - Health lamp off without AC; power-down keeps state, but green goes dark and more severe states still show
// - Eight POST lamps, bit 7 most significant
package bdl_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] BDL_CTRL_OFS   = 8'h00; // Identify command, boot stage, power
   localparam logic [7:0] BDL_COND_OFS   = 8'h04; // Condition bits per severity
   localparam logic [7:0] BDL_MEMERR_OFS = 8'h08; // Per-socket memory error flags
   localparam logic [7:0] BDL_POST_OFS   = 8'h0C; // POST progress code
   localparam logic [7:0] BDL_STAT_OFS   = 8'h10; // Read-only lamp state

   // ==========================================================
   // Field positions
   localparam int BDL_CTRL_ID_CMD_LSB = 0;  // 2 bits: identify command
   localparam int BDL_CTRL_ID_GO      = 2;  // Write 1 to issue the command
   localparam int BDL_CTRL_STAGE_LSB  = 4;  // 2 bits: controller boot stage
   localparam int BDL_CTRL_MGMT_RDY   = 6;  // Manageability up
   localparam int BDL_CTRL_SYS_ON     = 7;  // Host DC power on
   localparam int BDL_COND_DEG_LSB    = 0;  // 8 bits degraded causes
   localparam int BDL_COND_NF_LSB     = 8;  // 8 bits non-fatal causes
   localparam int BDL_COND_FAT_LSB    = 16; // 8 bits fatal causes

   // ==========================================================
   // Sizes and timing
   localparam int  BDL_FANS       = 3;
   localparam int  BDL_SOCKETS    = 8;
   localparam int  BDL_POST_BITS  = 8;
   localparam longint BDL_CLK_HZ  = 100_000_000;
   localparam int  BDL_ID_TIMEOUT_S = 15;
   localparam int  BDL_SLOW_HZ    = 1;
   localparam int  BDL_FAST_HZ    = 3;
   localparam int  BDL_SLOW_HALF  = int'(BDL_CLK_HZ / (2 * BDL_SLOW_HZ));
   localparam int  BDL_FAST_HALF  = int'(BDL_CLK_HZ / (2 * BDL_FAST_HZ));
   localparam longint BDL_ID_CYCLES = BDL_CLK_HZ * BDL_ID_TIMEOUT_S;
   localparam logic [31:0] BDL_ZERO_WORD = 32'h0000_0000;

   // ==========================================================
   // Enumerations
   typedef enum logic [1:0] {
      BDL_ID_CMD_OFF,
      BDL_ID_CMD_TIMED,
      BDL_ID_CMD_FOREVER
   } bdl_id_cmd_t;

   typedef enum logic [1:0] {
      BDL_STAGE_RUN,
      BDL_STAGE_LOADER,
      BDL_STAGE_IMAGE,
      BDL_STAGE_SELFTEST_FAIL
   } bdl_stage_t;

   typedef enum {
      BDL_ID_OFF,
      BDL_ID_SOLID,
      BDL_ID_BLINK_TIMED,
      BDL_ID_BLINK_FOREVER
   } bdl_id_state_t;

   // Health lamp shown colour per severity
   typedef enum logic [2:0] {
      BDL_H_OFF,
      BDL_H_GREEN,
      BDL_H_GREEN_BLINK,
      BDL_H_AMBER_BLINK,
      BDL_H_AMBER
   } bdl_health_t;

   // Lamp drive bundle
   typedef struct packed {
      logic [BDL_POST_BITS-1:0] post;
      logic [BDL_SOCKETS-1:0]   mem_fault;
      logic [BDL_FANS-1:0]      fan_fault;
      logic                     ident;
      logic                     green;
      logic                     amber;
   } bdl_lamps_t;

   // APB request bundle
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } bdl_apb_req_t;

endpackage

// ==== rtl/bdl_led_ctrl.sv ====
// Diagnostic LED controller: fan, memory, identify, health and POST lamps
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module bdl_led_ctrl
   import bdl_pkg::*;
#(
   parameter longint ID_CYCLES = BDL_ID_CYCLES
)
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire bdl_apb_req_t           apb_req,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [BDL_FANS-1:0]    fan_fault_in,
   input  wire logic [BDL_SOCKETS-1:0] socket_present,
   input  wire logic                   id_button,
   input  wire logic                   ac_present,
   output bdl_lamps_t                  lamps
);

   // ==========================================================
   // Bus decode
   logic       acc;
   logic       wr;
   logic [7:0] ctrl_q;
   logic [23:0] cond_q;
   logic [BDL_SOCKETS-1:0] memerr_q;
   logic [BDL_POST_BITS-1:0] post_q;
   logic       id_go;
   bdl_id_cmd_t id_cmd;
   bdl_stage_t stage;
   bdl_id_state_t id_q;
   bdl_health_t health_d;
   bdl_health_t health_q;
   logic       btn_q;
   logic [31:0] id_cnt_q;
   logic [31:0] slow_cnt_q;
   logic [31:0] fast_cnt_q;
   logic       slow_ph_q;
   logic       fast_ph_q;
   logic       sys_on_q;
   logic       ident_d;
   logic       btn_rise;
   logic       fatal_act;
   logic       nonfatal_act;
   logic       degraded_act;
   logic [31:0] stat_word;

   // Zero-wait slave: every access completes in its first access cycle
   assign acc     = apb_req.psel & apb_req.penable;
   assign wr      = acc & apb_req.pwrite;
   assign pready  = 1'b1;
   assign pslverr = acc & ~is_mapped(apb_req.paddr);

   // Address decode for the error path; the read mux decodes on its own
   function automatic logic is_mapped(input logic [7:0] a);
      return a == BDL_CTRL_OFS || a == BDL_COND_OFS || a == BDL_MEMERR_OFS
          || a == BDL_POST_OFS || a == BDL_STAT_OFS;
   endfunction

   // Write strobe for one register; strobe and address come in as arguments so that
   // a continuous assignment calling it still wakes up when they change
   function automatic logic wr_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] a);
      return strobe && addr == a;
   endfunction

   // Rising edge of the button; holding it down toggles only once
   assign btn_rise = id_button & ~btn_q;
   assign id_go  = wr_hit(wr, apb_req.paddr, BDL_CTRL_OFS) && apb_req.pwdata[BDL_CTRL_ID_GO];
   assign id_cmd = bdl_id_cmd_t'(apb_req.pwdata[BDL_CTRL_ID_CMD_LSB +: 2]);
   assign stage  = bdl_stage_t'(ctrl_q[BDL_CTRL_STAGE_LSB +: 2]);

   // Group activity; the meaning of each cause bit is left to software
   assign fatal_act    = cond_q[BDL_COND_FAT_LSB +: 8] != 8'h00;
   assign nonfatal_act = cond_q[BDL_COND_NF_LSB +: 8] != 8'h00;
   assign degraded_act = cond_q[BDL_COND_DEG_LSB +: 8] != 8'h00;

   // Status word mirrors the lamp registers, so software reads what the board shows
   assign stat_word = {8'h00, lamps.post, lamps.mem_fault, 2'b00, lamps.fan_fault, lamps.ident,
                       lamps.green, lamps.amber};

   // ==========================================================
   // Software registers
   // Control word; go and command bits are strobes and are never stored
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ctrl_q <= 8'h00;
      else if (wr_hit(wr, apb_req.paddr, BDL_CTRL_OFS))
         ctrl_q <= {apb_req.pwdata[7:4], 4'h0};
   end

   // Condition groups; hardware only ORs the bits of each group
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cond_q <= 24'h000000;
      else if (wr_hit(wr, apb_req.paddr, BDL_COND_OFS))
         cond_q <= apb_req.pwdata[23:0];
   end

   // Memory error flags, one per socket
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         memerr_q <= 8'h00;
      else if (wr_hit(wr, apb_req.paddr, BDL_MEMERR_OFS))
         memerr_q <= apb_req.pwdata[BDL_SOCKETS-1:0];
   end

   // POST code holds the last value written until the next write
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         post_q <= 8'h00;
      else if (wr_hit(wr, apb_req.paddr, BDL_POST_OFS))
         post_q <= apb_req.pwdata[BDL_POST_BITS-1:0];
   end

   // Read mux; unmapped reads return zero
   always_comb
   begin
      prdata = BDL_ZERO_WORD;
      if (acc && !apb_req.pwrite)
      begin
         case (apb_req.paddr)
            BDL_CTRL_OFS:   prdata = {24'h000000, ctrl_q};
            BDL_COND_OFS:   prdata = {8'h00, cond_q};
            BDL_MEMERR_OFS: prdata = {24'h000000, memerr_q};
            BDL_POST_OFS:   prdata = {24'h000000, post_q};
            BDL_STAT_OFS:   prdata = stat_word;
            default:        prdata = BDL_ZERO_WORD;
         endcase
      end
   end

   // ==========================================================
   // Blink generators, 1 Hz and 3 Hz
   // Half periods are fixed constants, so a short simulation never sees a lamp blink on
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         slow_cnt_q <= 32'h0000_0000;
         slow_ph_q  <= 1'b0;
      end
      else if (slow_cnt_q == 32'(BDL_SLOW_HALF - 1))
      begin
         slow_cnt_q <= 32'h0000_0000;
         slow_ph_q  <= ~slow_ph_q;
      end
      else
         slow_cnt_q <= slow_cnt_q + 32'h0000_0001;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fast_cnt_q <= 32'h0000_0000;
         fast_ph_q  <= 1'b0;
      end
      else if (fast_cnt_q == 32'(BDL_FAST_HALF - 1))
      begin
         fast_cnt_q <= 32'h0000_0000;
         fast_ph_q  <= ~fast_ph_q;
      end
      else
         fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
   end

   // ==========================================================
   // Identify lamp state machine; button edge and remote commands
   // Button level of the previous cycle; resets to the released level so reset makes no false press
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         btn_q <= 1'b0;
      else
         btn_q <= id_button;
   end

   // A remote command issued in the same cycle as a press takes priority
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         id_q <= BDL_ID_OFF;
      else if (id_go)
      begin
         case (id_cmd)
            BDL_ID_CMD_TIMED:   id_q <= BDL_ID_BLINK_TIMED;
            BDL_ID_CMD_FOREVER: id_q <= BDL_ID_BLINK_FOREVER;
            default:            id_q <= BDL_ID_OFF;
         endcase
      end
      else if (btn_rise)
         id_q <= (id_q == BDL_ID_SOLID) ? BDL_ID_OFF : BDL_ID_SOLID;
      else
      begin
         case (id_q)
            BDL_ID_BLINK_TIMED:
            begin
               if (id_cnt_q == 32'(ID_CYCLES - 1))
                  id_q <= BDL_ID_OFF;
            end
            BDL_ID_OFF, BDL_ID_SOLID, BDL_ID_BLINK_FOREVER:
               id_q <= id_q;
            default:
               id_q <= BDL_ID_OFF;
         endcase
      end
   end

   // ==========================================================
   // Identify timeout
   // Cleared outside the timed state, so every timed command runs a full span
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         id_cnt_q <= 32'h0000_0000;
      else if (id_go || id_q != BDL_ID_BLINK_TIMED)
         id_cnt_q <= 32'h0000_0000;
      else
         id_cnt_q <= id_cnt_q + 32'h0000_0001;
   end

   // ==========================================================
   // Health severity selection, most severe first
   always_comb
   begin
      if (fatal_act || stage == BDL_STAGE_SELFTEST_FAIL)
         health_d = BDL_H_AMBER;
      else if (nonfatal_act)
         health_d = BDL_H_AMBER_BLINK;
      else if (degraded_act || stage != BDL_STAGE_RUN || !ctrl_q[BDL_CTRL_MGMT_RDY])
         health_d = BDL_H_GREEN_BLINK;
      else
         health_d = BDL_H_GREEN;
   end

   // Track host power to freeze state across power-down
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sys_on_q <= 1'b0;
      else
         sys_on_q <= ctrl_q[BDL_CTRL_SYS_ON];
   end

   // While host is off the prior state is held, except green goes dark and more severe states still show
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         health_q <= BDL_H_OFF;
      else if (!ac_present)
         health_q <= BDL_H_OFF;
      else if (!ctrl_q[BDL_CTRL_SYS_ON])
      begin
         if (sys_on_q && health_q == BDL_H_GREEN)
            health_q <= BDL_H_OFF;
         else if (health_d > health_q && health_d != BDL_H_GREEN)
            health_q <= health_d; // New faults still show in standby; green stays dark
      end
      else
         health_q <= health_d;
   end

   // ==========================================================
   // Lamp level helpers
   // Level of a lamp that is either steady on or blinking with the given phase
   function automatic logic lamp_level(input logic steady, input logic blinking, input logic phase);
      return steady || (blinking && phase);
   endfunction

   // Boot stages override the identify lamp so a stuck controller stays visible
   always_comb
   begin
      case (stage)
         BDL_STAGE_LOADER:        ident_d = fast_ph_q;
         BDL_STAGE_IMAGE:         ident_d = 1'b1;
         BDL_STAGE_SELFTEST_FAIL: ident_d = 1'b1;
         default:
            ident_d = lamp_level(id_q == BDL_ID_SOLID,
                                 id_q == BDL_ID_BLINK_TIMED || id_q == BDL_ID_BLINK_FOREVER, slow_ph_q);
      endcase
   end

   // ==========================================================
   // Lamp outputs, all registered
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         lamps <= '0;
      else
      begin
         lamps.fan_fault <= fan_fault_in;
         lamps.mem_fault <= socket_present & memerr_q;
         lamps.post      <= post_q;
         lamps.green     <= lamp_level(health_q == BDL_H_GREEN, health_q == BDL_H_GREEN_BLINK, slow_ph_q);
         lamps.amber     <= lamp_level(health_q == BDL_H_AMBER, health_q == BDL_H_AMBER_BLINK, slow_ph_q);
         lamps.ident     <= ident_d;
      end
   end

endmodule

// ==== verification/bdl_led_monitor.sv ====
// Assertion checker for the diagnostic LED controller ports
`timescale 1ns/1ps
module bdl_led_monitor
   import bdl_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   rst,
   input wire bdl_apb_req_t           apb_req,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic [BDL_FANS-1:0]    fan_fault_in,
   input wire logic [BDL_SOCKETS-1:0] socket_present,
   input wire logic                   id_button,
   input wire logic                   ac_present,
   input wire bdl_lamps_t             lamps
);
   // ==========================
   // Access decode
   logic acc;
   logic wr_post;
   logic wr_fatal;
   assign acc      = apb_req.psel && apb_req.penable;
   assign wr_post  = acc && apb_req.pwrite && apb_req.paddr == BDL_POST_OFS;
   assign wr_fatal = acc && apb_req.pwrite && apb_req.paddr == BDL_COND_OFS && |apb_req.pwdata[23:16];

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ==========================
   // Lamp relations
   fan_lamp_a: assert property (lamps.fan_fault == $past(fan_fault_in))
      else $error("fan lamp differs from fan input");
   mem_socket_a: assert property ((lamps.mem_fault & ~$past(socket_present)) == 8'h00)
      else $error("memory lamp lit on empty socket");
   no_ac_dark_a: assert property (!ac_present [*4] |-> !lamps.green && !lamps.amber)
      else $error("health lamp lit without AC");
   fatal_amber_a: assert property (wr_fatal && ac_present ##1 ac_present [*3] |-> lamps.amber)
      else $error("fatal cause not steady amber");
   one_colour_a: assert property (!(lamps.green && lamps.amber))
      else $error("green and amber lit together");
   post_value_a: assert property (wr_post |-> ##2 lamps.post == $past(apb_req.pwdata[7:0], 2))
      else $error("POST lamps do not show written code");
   post_hold_a: assert property ($changed(lamps.post) |-> $past(wr_post, 2))
      else $error("POST lamps changed without a write");
   // Status word mirrors lamps, post byte MSB first
   stat_read_a: assert property (acc && !apb_req.pwrite && apb_req.paddr == BDL_STAT_OFS |->
      prdata == {8'h00, lamps.post, lamps.mem_fault, 2'b00, lamps.fan_fault, lamps.ident, lamps.green,
      lamps.amber})
      else $error("status word differs from lamps");
   unmapped_read_a: assert property (acc && !apb_req.pwrite && apb_req.paddr > BDL_STAT_OFS |->
      pslverr && prdata == 32'h0000_0000)
      else $error("unmapped read not refused");
endmodule

// ==== verification/bdl_host_model.sv ====
// Firmware side model: APB master used by controller and boot firmware
`timescale 1ns/1ps
module bdl_host_model
   import bdl_pkg::*;
(
   input wire logic         clk,
   output bdl_apb_req_t     req,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr
);
   initial req = '0;

   // ==========================
   // One transfer: setup phase, then access phase until ready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      // Access phase lasts until ready is seen at a rising edge; only the bench watchdog ends a dead wait
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      req <= '0;
   endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking testbench for the diagnostic LED controller
`timescale 1ns/1ps
module testbench;
   import bdl_pkg::*;
   localparam int ID_N = 100; // Short identify timeout keeps the run brief
   logic         clk, rst, btn, ac, e, pready, pslverr;
   logic [2:0]   fan;
   logic [7:0]   sock;
   logic [31:0]  q, prdata;
   bdl_apb_req_t apb_req;
   bdl_lamps_t   lamps;
   int           mismatches, n_checks;
   logic [23:0]  cv [4] = '{24'h000001, 24'h000101, 24'h010101, 24'h000000};
   logic [1:0]   ce [4] = '{2'b00, 2'b00, 2'b01, 2'b10};
   logic [7:0]   st [3] = '{8'hD0, 8'hE0, 8'hF0};
   logic [2:0]   se [3] = '{3'b000, 3'b100, 3'b101};

   bdl_led_ctrl #(.ID_CYCLES(ID_N)) i_bdl_led_ctrl (.clk(clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fan_fault_in(fan), .socket_present(sock), .id_button(btn),
      .ac_present(ac), .lamps(lamps));
   bdl_host_model i_bdl_host_model (.clk(clk), .req(apb_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // ==========================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d, checks %0d", mismatches, n_checks);
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_bdl_host_model.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a);
      i_bdl_host_model.xfer(1'b0, a, 32'h0, q, e);
   endtask
   task automatic hw(input logic [2:0] exp);
      repeat (4) @(posedge clk);
      check(32'({lamps.ident, lamps.green, lamps.amber}), 32'(exp));
   endtask

   // ==========================
   // Clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #100_000; // About 37 times the length of the test sequence
      mismatches++;
      stop_test();
   end

   // ==========================
   // Main sequence
   initial
   begin
      rst = 1'b1; btn = 1'b0; ac = 1'b0; fan = 3'h0; sock = 8'h00; mismatches = 0; n_checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wr(BDL_CTRL_OFS, 32'hC0);
      hw(3'b000);
      ac <= 1'b1;
      hw(3'b010);
      for (int i = 0; i < 4; i++)
      begin
         wr(BDL_COND_OFS, 32'(cv[i]));
         hw({1'b0, ce[i]});
      end
      wr(BDL_CTRL_OFS, 32'h40);
      hw(3'b000);
      wr(BDL_CTRL_OFS, 32'hC0);
      wr(BDL_COND_OFS, 32'h10000);
      wr(BDL_CTRL_OFS, 32'h40);
      wr(BDL_COND_OFS, 32'h0);
      hw(3'b001);
      wr(BDL_CTRL_OFS, 32'hC0);
      hw(3'b010);
      for (int i = 0; i < 3; i++)
      begin
         fan <= 3'(1 << i);
         repeat (3) @(posedge clk);
         check(32'(lamps.fan_fault), 32'(1 << i));
      end
      sock <= 8'h0F;
      wr(BDL_MEMERR_OFS, 32'h3C);
      repeat (3) @(posedge clk);
      check(32'(lamps.mem_fault), 32'h0C);
      wr(BDL_POST_OFS, 32'hA5);
      repeat (3) @(posedge clk);
      check(32'(lamps.post), 32'hA5);
      rd(BDL_STAT_OFS);
      check(q, 32'h00A5_0C22);
      rd(8'h14);
      check(32'(e), 32'h1);
      check(q, 32'h0);
      // Three presses: on, off, then on again
      for (int i = 0; i < 3; i++)
      begin
         btn <= 1'b1;
         repeat (2) @(posedge clk);
         btn <= 1'b0;
         hw({i != 1, 2'b10});
      end
      wr(BDL_CTRL_OFS, 32'hC5);
      repeat (ID_N + 10) @(posedge clk);
      hw(3'b010);
      wr(BDL_CTRL_OFS, 32'hC6);
      btn <= 1'b1;
      repeat (2) @(posedge clk);
      btn <= 1'b0;
      hw(3'b110);
      wr(BDL_CTRL_OFS, 32'hC4);
      hw(3'b010);
      for (int i = 0; i < 3; i++)
      begin
         wr(BDL_CTRL_OFS, 32'(st[i]));
         hw(se[i]);
      end
      stop_test();
   end
endmodule

bind bdl_led_ctrl bdl_led_monitor i_bdl_led_monitor (.clk, .rst, .apb_req, .prdata, .pready, .pslverr,
   .fan_fault_in, .socket_present, .id_button, .ac_present, .lamps);
